/* ris_params.svh */
`ifndef RIS_PARAMS_SVH
`define RIS_PARAMS_SVH
// -------------------------------------------------------------------------
// register offsets
// -------------------------------------------------------------------------
`define RIS_OFF_MCMD   8'h0c
`define RIS_OFF_STATE  8'h14
`define RIS_OFF_MASK   8'h2c
`define RIS_OFF_RAW    8'h30
`define RIS_OFF_CLR    8'h38
// -------------------------------------------------------------------------
// flag positions
// -------------------------------------------------------------------------
`define RIS_B_RXFULL   6
`define RIS_B_SRDREQ   16
`define RIS_B_SRDSTV   17
`define RIS_B_SWRREQ   18
`define RIS_B_MDONE    19
// -------------------------------------------------------------------------
// state register positions
// -------------------------------------------------------------------------
`define RIS_S_MBUSY    0
`define RIS_S_SRDBUSY  1
`define RIS_S_STRETCH  2
`define RIS_S_REFUSED  3
// -------------------------------------------------------------------------
// reset values and masks
// -------------------------------------------------------------------------
`define RIS_RST_RAW    32'h0000_0000
`define RIS_RST_MASK   32'h0000_0000
`define RIS_RST_MCMD   32'h0000_0000
`define RIS_FLAG_BITS  32'h000f_0040
`define RIS_RESP_OKAY  2'h0
`define RIS_RESP_SLVERR 2'h2
`endif

/* ris_pkg.sv */
`default_nettype none
package ris_pkg;
  typedef enum logic [2:0] {
    RIS_SEL_NONE,
    RIS_SEL_MCMD,
    RIS_SEL_STATE,
    RIS_SEL_MASK,
    RIS_SEL_RAW,
    RIS_SEL_CLR
  } ris_sel_e;
  typedef logic [31:0] ris_word_t;
endpackage
`default_nettype wire

/* ris_pin_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module ris_pin_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output var  logic start_det,
  output var  logic stop_det
);
  // -----------------------------------------------------------------------
  // two-flop synchronisers, third stage for edges
  // -----------------------------------------------------------------------
  logic [1:0] meta_q;
  logic [1:0] sync_q;
  logic [1:0] prev_q;
  wire        sda_fall;
  wire        sda_rise;
  wire        scl_high;

  assign scl_high = sync_q[1] & prev_q[1];
  assign sda_fall = ~sync_q[0] & prev_q[0];
  assign sda_rise = sync_q[0] & ~prev_q[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q    <= 2'h3;
      sync_q    <= 2'h3;
      prev_q    <= 2'h3;
      start_det <= 1'b0;
      stop_det  <= 1'b0;
    end else if (ce) begin
      meta_q    <= {scl_in, sda_in};
      sync_q    <= meta_q;
      prev_q    <= sync_q;
      start_det <= scl_high & sda_fall;
      stop_det  <= scl_high & sda_rise;
    end
  end
endmodule // ris_pin_sync
`default_nettype wire

/* ris_raw_status.sv */
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "ris_params.svh"
module ris_raw_status #(
  parameter int AW = 8
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          ce,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output var  logic          s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output var  logic          s_axi_wready,
  output var  logic [1:0]    s_axi_bresp,
  output var  logic          s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output var  logic          s_axi_arready,
  output var  logic [31:0]   s_axi_rdata,
  output var  logic [1:0]    s_axi_rresp,
  output var  logic          s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire logic          rx_full,
  input  wire logic          rx_rd,
  input  wire logic          tx_empty,
  input  wire logic          tx_wr,
  input  wire logic          slv_rd_addr,
  input  wire logic          slv_wr_addr,
  input  wire logic          scl_in,
  input  wire logic          sda_in,
  output var  logic          scl_out,
  output var  logic          scl_oe,
  output var  logic          tx_flush,
  output var  logic          mcmd_start,
  output var  logic [31:0]   mcmd_word,
  output var  logic          irq
);
  // -----------------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------------
  function automatic ris_pkg::ris_sel_e reg_sel(input logic [AW-1:0] a);
    logic [7:0] o;
    o = 8'(a);
    case (o)
      `RIS_OFF_MCMD:  reg_sel = ris_pkg::RIS_SEL_MCMD;
      `RIS_OFF_STATE: reg_sel = ris_pkg::RIS_SEL_STATE;
      `RIS_OFF_MASK:  reg_sel = ris_pkg::RIS_SEL_MASK;
      `RIS_OFF_RAW:   reg_sel = ris_pkg::RIS_SEL_RAW;
      `RIS_OFF_CLR:   reg_sel = ris_pkg::RIS_SEL_CLR;
      default:        reg_sel = ris_pkg::RIS_SEL_NONE;
    endcase
  endfunction

  function automatic ris_pkg::ris_word_t lanes(input logic [3:0] s);
    lanes = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // -----------------------------------------------------------------------
  // state
  // -----------------------------------------------------------------------
  logic [AW-1:0]        aw_addr_q;
  logic                 aw_have_q;
  ris_pkg::ris_word_t   wdata_q;
  logic [3:0]           wstrb_q;
  logic                 w_have_q;
  ris_pkg::ris_word_t   mask_q;
  logic                 rx_full_q;
  logic                 rxfull_q;
  logic                 srdreq_q;
  logic                 srdstv_q;
  logic                 swrreq_q;
  logic                 mdone_q;
  logic                 pend_rd_q;
  logic                 pend_wr_q;
  logic                 srd_busy_q;
  logic                 mbusy_q;
  logic                 refused_q;
  wire                  stop_det;

  ris_pin_sync u_sync (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .start_det (),
    .stop_det  (stop_det)
  );

  // -----------------------------------------------------------------------
  // bus decode
  // -----------------------------------------------------------------------
  ris_pkg::ris_sel_e    wsel;
  ris_pkg::ris_sel_e    rsel;
  ris_pkg::ris_word_t   wlanes;
  ris_pkg::ris_word_t   clr_bits;
  ris_pkg::ris_word_t   raw_w;
  ris_pkg::ris_word_t   state_w;
  ris_pkg::ris_word_t   rd_mux;
  wire                  aw_ok;
  wire                  w_ok;
  wire                  wr_go;
  wire                  ar_ok;
  wire                  mask_wr;
  wire                  mcmd_wr;
  wire                  mcmd_take;
  wire                  wr_bad;
  wire                  rd_bad;

  assign aw_ok     = s_axi_awvalid & s_axi_awready;
  assign w_ok      = s_axi_wvalid & s_axi_wready;
  assign ar_ok     = s_axi_arvalid & s_axi_arready;
  assign wr_go     = aw_have_q & w_have_q & ~s_axi_bvalid;
  assign wsel      = reg_sel(aw_addr_q);
  assign rsel      = reg_sel(s_axi_araddr);
  assign wlanes    = lanes(wstrb_q);
  assign mask_wr   = wr_go & (wsel == ris_pkg::RIS_SEL_MASK);
  assign mcmd_wr   = wr_go & (wsel == ris_pkg::RIS_SEL_MCMD);
  assign wr_bad    = wsel == ris_pkg::RIS_SEL_NONE;
  assign rd_bad    = rsel == ris_pkg::RIS_SEL_NONE;
  assign clr_bits  = (wr_go & (wsel == ris_pkg::RIS_SEL_CLR)) ?
                     (wdata_q & wlanes) : 32'h0000_0000;
  assign mcmd_take = mcmd_wr & ~mdone_q & ~mbusy_q;

  // -----------------------------------------------------------------------
  // flag next values
  // -----------------------------------------------------------------------
  wire rd_req_now;
  wire wr_req_now;
  wire rd_fire;
  wire wr_fire;
  wire pend_rd_d;
  wire pend_wr_d;
  wire rxfull_d;
  wire srdreq_d;
  wire srdstv_d;
  wire swrreq_d;
  wire mdone_d;
  wire srd_busy_d;
  wire mbusy_d;

  assign rd_req_now = slv_rd_addr | pend_rd_q;
  assign wr_req_now = slv_wr_addr | pend_wr_q;
  assign rd_fire    = rd_req_now & ~mdone_q;
  assign wr_fire    = wr_req_now & ~mdone_q;
  assign pend_rd_d  = rd_req_now & mdone_q;
  assign pend_wr_d  = wr_req_now & mdone_q;
  assign rxfull_d   = (rx_full & ~rx_full_q) | (rxfull_q & ~rx_rd);
  assign srdreq_d   = rd_fire |
                      (srdreq_q & ~tx_wr & ~clr_bits[`RIS_B_SRDREQ]);
  assign srd_busy_d = rd_fire | (srd_busy_q & ~stop_det);
  assign srdstv_d   = srd_busy_q & tx_empty & ~tx_wr & ~stop_det;
  assign swrreq_d   = wr_fire |
                      (swrreq_q & ~clr_bits[`RIS_B_SWRREQ]);
  assign mbusy_d    = mcmd_take | (mbusy_q & ~stop_det);
  assign mdone_d    = (mbusy_q & stop_det) |
                      (mdone_q & ~clr_bits[`RIS_B_MDONE]);

  // -----------------------------------------------------------------------
  // register views
  // -----------------------------------------------------------------------
  always_comb begin
    raw_w                = `RIS_RST_RAW;
    raw_w[`RIS_B_RXFULL] = rxfull_q;
    raw_w[`RIS_B_SRDREQ] = srdreq_q;
    raw_w[`RIS_B_SRDSTV] = srdstv_q;
    raw_w[`RIS_B_SWRREQ] = swrreq_q;
    raw_w[`RIS_B_MDONE]  = mdone_q;
  end

  always_comb begin
    state_w                 = 32'h0000_0000;
    state_w[`RIS_S_MBUSY]   = mbusy_q;
    state_w[`RIS_S_SRDBUSY] = srd_busy_q;
    state_w[`RIS_S_STRETCH] = scl_oe;
    state_w[`RIS_S_REFUSED] = refused_q;
  end

  always_comb begin
    case (rsel)
      ris_pkg::RIS_SEL_MCMD:  rd_mux = mcmd_word;
      ris_pkg::RIS_SEL_STATE: rd_mux = state_w;
      ris_pkg::RIS_SEL_MASK:  rd_mux = mask_q;
      ris_pkg::RIS_SEL_RAW:   rd_mux = raw_w;
      default:                rd_mux = 32'h0000_0000;
    endcase
  end

  // -----------------------------------------------------------------------
  // write channels
  // -----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_q     <= '0;
      aw_have_q     <= 1'b0;
      s_axi_awready <= 1'b1;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      w_have_q      <= 1'b0;
      s_axi_wready  <= 1'b1;
    end else if (ce) begin
      if (aw_ok) begin
        aw_addr_q     <= s_axi_awaddr;
        aw_have_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_awready <= 1'b1;
      end
      if (w_ok) begin
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        w_have_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_wready <= 1'b1;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RIS_RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_bad ? `RIS_RESP_SLVERR : `RIS_RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------------
  // read channel
  // -----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RIS_RESP_OKAY;
    end else if (ce) begin
      if (ar_ok) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_mux;
        s_axi_rresp   <= rd_bad ? `RIS_RESP_SLVERR : `RIS_RESP_OKAY;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------------
  // control registers
  // -----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_q     <= `RIS_RST_MASK;
      mcmd_word  <= `RIS_RST_MCMD;
      mcmd_start <= 1'b0;
      refused_q  <= 1'b0;
    end else if (ce) begin
      if (mask_wr) begin
        mask_q <= ((mask_q & ~wlanes) | (wdata_q & wlanes)) & `RIS_FLAG_BITS;
      end
      if (mcmd_take) begin
        mcmd_word <= wdata_q;
      end
      mcmd_start <= mcmd_take;
      if (mcmd_wr) begin
        refused_q <= ~mcmd_take;
      end
    end
  end

  // -----------------------------------------------------------------------
  // raw flags and link side
  // -----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_full_q  <= 1'b0;
      rxfull_q   <= 1'b0;
      srdreq_q   <= 1'b0;
      srdstv_q   <= 1'b0;
      swrreq_q   <= 1'b0;
      mdone_q    <= 1'b0;
      pend_rd_q  <= 1'b0;
      pend_wr_q  <= 1'b0;
      srd_busy_q <= 1'b0;
      mbusy_q    <= 1'b0;
    end else if (ce) begin
      rx_full_q  <= rx_full;
      rxfull_q   <= rxfull_d;
      srdreq_q   <= srdreq_d;
      srdstv_q   <= srdstv_d;
      swrreq_q   <= swrreq_d;
      mdone_q    <= mdone_d;
      pend_rd_q  <= pend_rd_d;
      pend_wr_q  <= pend_wr_d;
      srd_busy_q <= srd_busy_d;
      mbusy_q    <= mbusy_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_out  <= 1'b0;
      scl_oe   <= 1'b0;
      tx_flush <= 1'b0;
      irq      <= 1'b0;
    end else if (ce) begin
      scl_out  <= 1'b0;
      scl_oe   <= pend_rd_d | pend_wr_d;
      tx_flush <= rd_fire;
      irq      <= |(raw_w & mask_q);
    end
  end
endmodule // ris_raw_status
`default_nettype wire

/* ris_bus_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ris_bus_model (
  input  wire logic go,
  input  wire logic scl_line,
  output var  logic scl_drv,
  output var  logic sda_drv,
  output var  logic done
);
  // ------
  // one frame: start, four clocks, stop
  // ------
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
    done = 1'b0;
  end
  always @(posedge go) begin
    done = 1'b0;
    sda_drv = 1'b0;
    #80;
    repeat (4) begin
      scl_drv = 1'b0;
      #80;
      scl_drv = 1'b1;
      wait (scl_line === 1'b1);
      #80;
    end
    sda_drv = 1'b1;
    #80;
    done = 1'b1;
  end
endmodule // ris_bus_model
`default_nettype wire

/* ris_raw_status_props.sv */
`timescale 1ns/10ps
`default_nettype none
module ris_raw_status_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        slv_rd_addr,
  input wire logic        slv_wr_addr,
  input wire logic        s_axi_bvalid,
  input wire logic        scl_out,
  input wire logic        scl_oe,
  input wire logic        tx_flush,
  input wire logic        mcmd_start,
  input wire logic [31:0] mcmd_word
);
  // ------
  // properties
  // ------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_flush_pulse;
    tx_flush |=> !tx_flush;
  endproperty
  property p_flush_cause;
    tx_flush |-> $past(slv_rd_addr) || $fell(scl_oe);
  endproperty
  property p_oe_low;
    scl_oe |-> !scl_out;
  endproperty
  property p_oe_cause;
    $rose(scl_oe) |-> $past(slv_rd_addr || slv_wr_addr);
  endproperty
  property p_oe_hold;
    scl_oe && !s_axi_bvalid |=> scl_oe;
  endproperty
  property p_oe_release;
    $fell(scl_oe) |-> $past(s_axi_bvalid);
  endproperty
  property p_start_resp;
    mcmd_start |-> $rose(s_axi_bvalid);
  endproperty
  property p_start_gap;
    mcmd_start |=> !mcmd_start [*2];
  endproperty
  property p_word_hold;
    !mcmd_start |-> $stable(mcmd_word);
  endproperty
  a_flush_pulse: assert property (p_flush_pulse) else $error("flush longer than one cycle");
  a_flush_cause: assert property (p_flush_cause) else $error("flush without read request");
  a_oe_low: assert property (p_oe_low) else $error("stretch does not drive low");
  a_oe_cause: assert property (p_oe_cause) else $error("stretch without slave request");
  a_oe_hold: assert property (p_oe_hold) else $error("stretch dropped early");
  a_oe_release: assert property (p_oe_release) else $error("stretch released without clear");
  a_start_resp: assert property (p_start_resp) else $error("command start off response");
  a_start_gap: assert property (p_start_gap) else $error("command starts too close");
  a_word_hold: assert property (p_word_hold) else $error("command word changed alone");
  c_flush: cover property (tx_flush);
  c_start: cover property (mcmd_start);
  c_stretch: cover property ($rose(scl_oe));
endmodule // ris_raw_status_chk
bind ris_raw_status ris_raw_status_chk i_chk (
  .aclk(aclk), .aresetn(aresetn), .slv_rd_addr(slv_rd_addr), .slv_wr_addr(slv_wr_addr),
  .s_axi_bvalid(s_axi_bvalid), .scl_out(scl_out), .scl_oe(scl_oe), .tx_flush(tx_flush),
  .mcmd_start(mcmd_start), .mcmd_word(mcmd_word)
);
`default_nettype wire

/* ris_raw_status_test.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ris_params.svh"
module ris_raw_status_test;
  logic        aclk, aresetn, ce, go, done, bus_scl, bus_sda;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd, mcmd_word;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        rx_full, rx_rd, tx_empty, tx_wr, slv_rd_addr, slv_wr_addr;
  logic        scl_out, scl_oe, tx_flush, mcmd_start, irq;
  int          failures, n_checks, cyc, n_flush, n_start;
  wire logic   scl_line = bus_scl & ~(scl_oe & ~scl_out);
  ris_raw_status #(.AW(8)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_full(rx_full), .rx_rd(rx_rd), .tx_empty(tx_empty), .tx_wr(tx_wr),
    .slv_rd_addr(slv_rd_addr), .slv_wr_addr(slv_wr_addr), .scl_in(scl_line), .sda_in(bus_sda),
    .scl_out(scl_out), .scl_oe(scl_oe), .tx_flush(tx_flush), .mcmd_start(mcmd_start),
    .mcmd_word(mcmd_word), .irq(irq)
  );
  ris_bus_model i_bus (
    .go(go), .scl_line(scl_line), .scl_drv(bus_scl), .sda_drv(bus_sda), .done(done)
  );
  // ------
  // helpers
  // ------
  always #10 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (tx_flush === 1'b1) n_flush++;
    if (mcmd_start === 1'b1) n_start++;
    if (cyc == 20000) begin
      failures++;
      test_done;
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    resp = bresp;
    bready <= 1'b0;
  endtask
  task axr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task ev(input logic [3:0] k);
    @(posedge aclk);
    {tx_wr, slv_wr_addr, slv_rd_addr, rx_rd} <= k;
    @(posedge aclk);
    {tx_wr, slv_wr_addr, slv_rd_addr, rx_rd} <= 4'h0;
  endtask
  task chk_raw(input logic [31:0] e);
    repeat (3) @(posedge aclk);
    axr(`RIS_OFF_RAW);
    chk(rd, e);
  endtask
  task frame;
    @(posedge aclk);
    go <= 1'b1;
    forever begin
      @(posedge aclk);
      if (done) break;
    end
    go <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask
  task test_done;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ------
  // sequence
  // ------
  initial begin
    {aclk, aresetn, go, awvalid, wvalid, bready, arvalid, rready} = '0;
    {rx_full, rx_rd, tx_empty, tx_wr, slv_rd_addr, slv_wr_addr} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    ce = 1'b1;
    {failures, n_checks, cyc, n_flush, n_start} = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    chk_raw(`RIS_RST_RAW);
    axr(`RIS_OFF_MASK);
    chk(rd, `RIS_RST_MASK);
    axw(`RIS_OFF_RAW, 32'hffff_ffff);
    chk_raw(32'h0);
    axw(`RIS_OFF_MASK, 32'hffff_ffff);
    chk(resp, `RIS_RESP_OKAY);
    axw(8'h3c, 32'hffff_ffff);
    chk(resp, `RIS_RESP_SLVERR);
    axr(`RIS_OFF_MASK);
    chk(rd, `RIS_FLAG_BITS);
    axr(8'h3c);
    chk(resp, `RIS_RESP_SLVERR);
    rx_full <= 1'b1;
    chk_raw(32'h1 << `RIS_B_RXFULL);
    chk(irq, 1'b1);
    axw(`RIS_OFF_MASK, 32'h0);
    repeat (3) @(posedge aclk);
    chk(irq, 1'b0);
    chk_raw(32'h1 << `RIS_B_RXFULL);
    axw(`RIS_OFF_MASK, `RIS_FLAG_BITS);
    rx_full <= 1'b0;
    ev(4'h1);
    chk_raw(32'h0);
    ev(4'h2);
    tx_empty <= 1'b1;
    chk_raw(32'h3 << `RIS_B_SRDREQ);
    chk(n_flush, 1);
    tx_empty <= 1'b0;
    ev(4'h8);
    chk_raw(32'h0);
    tx_empty <= 1'b1;
    chk_raw(32'h1 << `RIS_B_SRDSTV);
    frame;
    chk_raw(32'h0);
    tx_empty <= 1'b0;
    ev(4'h2);
    ev(4'h4);
    chk_raw(32'h5 << `RIS_B_SRDREQ);
    axw(`RIS_OFF_CLR, 32'hffff_ffff);
    chk_raw(32'h0);
    chk(n_flush, 2);
    axw(`RIS_OFF_MCMD, 32'h0000_00a5);
    frame;
    chk_raw(32'h1 << `RIS_B_MDONE);
    chk(irq, 1'b1);
    chk(mcmd_word, 32'h0000_00a5);
    axr(`RIS_OFF_STATE);
    chk(rd[`RIS_S_REFUSED], 1'b0);
    axw(`RIS_OFF_MCMD, 32'h0000_005a);
    axr(`RIS_OFF_STATE);
    chk(rd[`RIS_S_REFUSED], 1'b1);
    chk(n_start, 1);
    ev(4'h6);
    chk_raw(32'h1 << `RIS_B_MDONE);
    chk(scl_oe, 1'b1);
    chk(n_flush, 2);
    axw(`RIS_OFF_CLR, 32'h1 << `RIS_B_MDONE);
    chk_raw(32'h5 << `RIS_B_SRDREQ);
    chk(scl_oe, 1'b0);
    chk(n_flush, 3);
    axw(`RIS_OFF_MCMD, 32'h0000_005a);
    repeat (2) @(posedge aclk);
    chk(n_start, 2);
    chk(mcmd_word, 32'h0000_005a);
    axr(`RIS_OFF_MCMD);
    chk(rd, 32'h0000_005a);
    ce <= 1'b0;
    ev(4'h2);
    ce <= 1'b1;
    chk_raw(32'h5 << `RIS_B_SRDREQ);
    chk(n_flush, 3);
    test_done;
  end
endmodule // ris_raw_status_test
`default_nettype wire
